//--- include/readout_pkg.sv
// constants and types shared by the frame readout sequencer and its column scanner
// assumes clk is the pixel timing clock; all counts are in clk cycles
package readout_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int NUM_COLS    = 320;
  localparam int NUM_ROWS    = 256;
  localparam int COL_W       = 9;
  localparam int ROW_W       = 8;
  localparam int SLOT_CYCLES = 4;
  localparam int INTEG_W     = 32;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 20_000_000;
  localparam int ROW_BLANK_NS     = 4320;
  // least time, so round up to whole cycles
  localparam int ROW_BLANK_CYCLES = (ROW_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MIN_LOW_PULSES   = 25;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_PIN_LEVEL  = 1'b1;
  localparam logic RST_PIXEL_HELD = 1'b1;

  // ----------------------------------------------------------------
  // row sequencer states, one bit per step except ST_BLANK to ST_SIGX and ST_SCAN to ST_DONE
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INTEG = 3'h0,
    ST_HOLD  = 3'h1,
    ST_SIGX  = 3'h3,
    ST_RSTP  = 3'h2,
    ST_RSTX  = 3'h6,
    ST_SCAN  = 3'h7,
    ST_BLANK = 3'h5,
    ST_DONE  = 3'h4
  } seq_state_t;

endpackage : readout_pkg

//--- include/scan_if.sv
// link between the row sequencer and the column scanner
// assumes both ends share one clock
`timescale 1ns/1ps
interface scan_if #(parameter int COL_W = 9);
  logic             start;     // begin scanning a row
  logic             abort;     // drop the row scan at once
  logic             done;      // one-cycle pulse after the last slot
  logic             video_en;  // a pixel slot is on the video output
  logic             sel_reset; // 0 signal level, 1 reset level
  logic             trig;      // conversion trigger
  logic [COL_W-1:0] col;       // column being shown

  modport ctl  (output start, output abort,
                input done, input video_en, input sel_reset, input trig, input col);
  modport scan (input start, input abort,
                output done, output video_en, output sel_reset, output trig, output col);
endinterface : scan_if

//--- src/pixel_slot.sv
// column scanner: walks one row, one four-cycle slot per pixel
// assumes start is a one-cycle pulse from the row sequencer on the same clock
`timescale 1ns/1ps
module pixel_slot
  import readout_pkg::*;
#(
  parameter int NUM_COLS_P = NUM_COLS
)(
  input wire logic clk,   // pixel timing clock
  input wire logic rst_n, // synchronous reset, active low
  scan_if.scan     sif    // sequencer link
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NUM_COLS_P < 1 || NUM_COLS_P > (1 << COL_W)) begin : g_chk
    $error("pixel_slot: column count does not fit the column index");
  end

  // every column up to the last is read
  localparam logic [COL_W-1:0] LAST_COL = COL_W'(NUM_COLS_P - 1);

  logic             run_r,  run_nxt;
  logic [1:0]       ph_r,   ph_nxt;
  logic [COL_W-1:0] col_r,  col_nxt;
  logic             done_r, done_nxt;
  logic             sel_r,  sel_nxt;
  logic             trig_r, trig_nxt;

  // ----------------------------------------------------------------
  // slot sequencing
  // ----------------------------------------------------------------
  // next slot, phase and column
  always_comb begin
    run_nxt  = run_r;
    ph_nxt   = ph_r;
    col_nxt  = col_r;
    done_nxt = 1'b0;
    if (sif.abort) begin
      run_nxt = 1'b0;
    end else if (sif.start) begin
      run_nxt = 1'b1;
      ph_nxt  = 2'h0;
      col_nxt = '0;
    end else if (run_r) begin
      ph_nxt = ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        if (col_r == LAST_COL) begin
          run_nxt  = 1'b0;
          done_nxt = 1'b1;
        end else begin
          col_nxt = col_r + COL_W'(1);
        end
      end
    end
    sel_nxt  = run_nxt & ph_nxt[1];
    trig_nxt = run_nxt & ph_nxt[0];
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_r  <= 1'b0;
      ph_r   <= 2'h0;
      col_r  <= '0;
      done_r <= 1'b0;
      sel_r  <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      run_r  <= run_nxt;
      ph_r   <= ph_nxt;
      col_r  <= col_nxt;
      done_r <= done_nxt;
      sel_r  <= sel_nxt;
      trig_r <= trig_nxt;
    end
  end

  assign sif.video_en  = run_r;
  assign sif.sel_reset = sel_r;
  assign sif.trig      = trig_r;
  assign sif.col       = col_r;
  assign sif.done      = done_r;

endmodule : pixel_slot

//--- src/frame_readout.sv
// frame readout sequencer: integration, global hold, row walk and video slots
// assumes clk is the pixel timing clock and frame_start_pulse comes from a pin
`timescale 1ns/1ps
module frame_readout
  import readout_pkg::*;
#(
  parameter int NUM_ROWS_P  = NUM_ROWS,
  parameter int NUM_COLS_P  = NUM_COLS,
  parameter int ROW_BLANK_P = ROW_BLANK_CYCLES
)(
  input  wire logic               clk,                // pixel timing clock
  input  wire logic               rst_n,              // synchronous reset, active low
  input  wire logic               frame_start_pulse,  // low integrates, high scans
  output logic                    integrating,        // pixels integrating
  output logic [INTEG_W-1:0]      integ_cycles,       // last low period in clocks
  output logic                    global_hold,        // all-pixel sample and hold pulse
  output logic                    pixel_reset_on,     // pixel resets engaged
  output logic [ROW_W-1:0]        row_sel,            // selected row
  output logic                    row_active,         // a row is selected
  output logic                    row_signal_xfer,    // signal transfer pulse
  output logic                    row_pixel_reset,    // row reset pulse
  output logic                    row_reset_xfer,     // reset level transfer pulse
  output logic                    video_en,           // pixel slot on video
  output logic                    video_sel_reset,    // 0 signal, 1 reset level
  output logic [COL_W-1:0]        col_index,          // column on video
  output logic                    conversion_trigger, // converter strobe
  output logic                    frame_done          // last row scanned pulse
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NUM_ROWS_P < 1 || NUM_ROWS_P > (1 << ROW_W)) begin : g_chk_rows
    $error("frame_readout: row count does not fit the row index");
  end
  if (ROW_BLANK_P < 1 || ROW_BLANK_P > 65535) begin : g_chk_blank
    $error("frame_readout: row blank count out of range");
  end

  localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(NUM_ROWS_P - 1);
  localparam logic [15:0]      BLANK_END = 16'(ROW_BLANK_P - 1);

  // ----------------------------------------------------------------
  // start pulse synchroniser and edge detection
  // ----------------------------------------------------------------
  logic pin_s1_r, pin_s2_r, pin_d_r;
  logic rise, fall;

  // two flops ahead of any logic; only pin_s2_r and its delayed copy pin_d_r are looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r <= RST_PIN_LEVEL;
      pin_s2_r <= RST_PIN_LEVEL;
      pin_d_r  <= RST_PIN_LEVEL;
    end else begin
      pin_s1_r <= frame_start_pulse;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;

  // ----------------------------------------------------------------
  // column scanner
  // ----------------------------------------------------------------
  scan_if #(.COL_W(COL_W)) sif ();

  pixel_slot #(
    .NUM_COLS_P (NUM_COLS_P)
  ) u_slot (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif)
  );

  // ----------------------------------------------------------------
  // row sequencer
  // ----------------------------------------------------------------
  seq_state_t          st_r,    st_nxt;
  logic [ROW_W-1:0]    row_r,   row_nxt;
  logic [15:0]         blk_r,   blk_nxt;
  logic [INTEG_W-1:0]  icnt_r,  icnt_nxt;
  logic [INTEG_W-1:0]  ilast_r, ilast_nxt;
  logic                prst_r,  prst_nxt;
  logic                hold_r,  hold_nxt;
  logic                sigx_r,  sigx_nxt;
  logic                rstp_r,  rstp_nxt;
  logic                rstx_r,  rstx_nxt;
  logic                fdone_r, fdone_nxt;
  logic                integ_r, integ_nxt;
  logic                ract_r,  ract_nxt;
  logic                start_nxt;
  logic                abort_nxt;

  // next state of the row walk
  always_comb begin
    st_nxt    = st_r;
    row_nxt   = row_r;
    blk_nxt   = blk_r;
    icnt_nxt  = icnt_r;
    ilast_nxt = ilast_r;
    prst_nxt  = prst_r;
    hold_nxt  = 1'b0;
    sigx_nxt  = 1'b0;
    rstp_nxt  = 1'b0;
    rstx_nxt  = 1'b0;
    fdone_nxt = 1'b0;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    case (st_r)
      ST_INTEG: begin
        icnt_nxt = icnt_r + INTEG_W'(1);
        if (rise) begin
          ilast_nxt = icnt_r;
          hold_nxt  = 1'b1;
          st_nxt    = ST_HOLD;
        end
      end
      ST_HOLD: begin
        row_nxt  = '0;
        sigx_nxt = 1'b1;
        st_nxt   = ST_SIGX;
      end
      ST_SIGX: begin
        rstp_nxt = 1'b1;
        prst_nxt = 1'b1;
        st_nxt   = ST_RSTP;
      end
      ST_RSTP: begin
        rstx_nxt = 1'b1;
        st_nxt   = ST_RSTX;
      end
      ST_RSTX: begin
        // hand the row to the column scan
        start_nxt = 1'b1;
        st_nxt    = ST_SCAN;
      end
      ST_SCAN: begin
        if (sif.done) begin
          // every row down to the last
          if (row_r == LAST_ROW) begin
            fdone_nxt = 1'b1;
            st_nxt    = ST_DONE;
          end else begin
            blk_nxt = '0;
            st_nxt  = ST_BLANK;
          end
        end
      end
      ST_BLANK: begin
        blk_nxt = blk_r + 16'h0001;
        if (blk_r == BLANK_END) begin
          row_nxt  = row_r + ROW_W'(1);
          sigx_nxt = 1'b1;
          st_nxt   = ST_SIGX;
        end
      end
      ST_DONE: begin
        // wait for the fall below
      end
      default: begin
        st_nxt = ST_DONE;
      end
    endcase
    // fall releases every pixel reset at once; a fall mid-frame abandons the frame
    if (fall && st_r != ST_INTEG) begin
      abort_nxt = 1'b1;
      prst_nxt  = 1'b0;
      icnt_nxt  = INTEG_W'(1);
      sigx_nxt  = 1'b0;
      rstp_nxt  = 1'b0;
      rstx_nxt  = 1'b0;
      start_nxt = 1'b0;
      st_nxt    = ST_INTEG;
    end
    integ_nxt = (st_nxt == ST_INTEG);
    ract_nxt  = (st_nxt != ST_INTEG) && (st_nxt != ST_HOLD) && (st_nxt != ST_DONE);
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r    <= ST_DONE;
      row_r   <= '0;
      blk_r   <= 16'h0000;
      icnt_r  <= '0;
      ilast_r <= '0;
      prst_r  <= RST_PIXEL_HELD;
      hold_r  <= 1'b0;
      sigx_r  <= 1'b0;
      rstp_r  <= 1'b0;
      rstx_r  <= 1'b0;
      fdone_r <= 1'b0;
      integ_r <= 1'b0;
      ract_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      row_r   <= row_nxt;
      blk_r   <= blk_nxt;
      icnt_r  <= icnt_nxt;
      ilast_r <= ilast_nxt;
      prst_r  <= prst_nxt;
      hold_r  <= hold_nxt;
      sigx_r  <= sigx_nxt;
      rstp_r  <= rstp_nxt;
      rstx_r  <= rstx_nxt;
      fdone_r <= fdone_nxt;
      integ_r <= integ_nxt;
      ract_r  <= ract_nxt;
    end
  end

  // scanner controls are combinational; the scanner registers them itself
  assign sif.start = start_nxt;
  assign sif.abort = abort_nxt;

  // ----------------------------------------------------------------
  // outputs, each straight from a flop
  // ----------------------------------------------------------------
  // video and trigger from the scanner, set by start and cleared after the last slot or by abort
  assign integrating        = integ_r;
  assign integ_cycles       = ilast_r;
  assign global_hold        = hold_r;
  assign pixel_reset_on     = prst_r;
  assign row_sel            = row_r;
  assign row_active         = ract_r;
  assign row_signal_xfer    = sigx_r;
  assign row_pixel_reset    = rstp_r;
  assign row_reset_xfer     = rstx_r;
  assign video_en           = sif.video_en;
  assign video_sel_reset    = sif.sel_reset;
  assign col_index          = sif.col;
  assign conversion_trigger = sif.trig;
  assign frame_done         = fdone_r;

endmodule : frame_readout

//--- testbench/readout_chk.sv
// checker for the frame readout sequencer, bound to its top module
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module readout_chk
  import readout_pkg::*;
#(
  parameter int NUM_ROWS_P  = NUM_ROWS,
  parameter int NUM_COLS_P  = NUM_COLS,
  parameter int ROW_BLANK_P = ROW_BLANK_CYCLES
)(
  input wire logic             clk,                // pixel clock
  input wire logic             rst_n,              // reset, active low
  input wire logic             frame_start_pulse,  // start pin
  input wire logic             integrating,        // integrating
  input wire logic             global_hold,        // hold pulse
  input wire logic             pixel_reset_on,     // resets engaged
  input wire logic [ROW_W-1:0] row_sel,            // selected row
  input wire logic             row_signal_xfer,    // signal transfer
  input wire logic             row_pixel_reset,    // row reset
  input wire logic             row_reset_xfer,     // reset transfer
  input wire logic             video_en,           // slot on video
  input wire logic             video_sel_reset,    // half of slot
  input wire logic [COL_W-1:0] col_index,          // column
  input wire logic             conversion_trigger, // converter strobe
  input wire logic             frame_done          // frame end pulse
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] row_seen_r;
  logic [15:0]      gap_r;
  // last row seen on video, idle cycles since video stopped
  always_ff @(posedge clk) begin
    if (video_en) row_seen_r <= row_sel;
    gap_r <= video_en ? 16'h0000 : gap_r + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_HOLD_ROW0: assert property (global_hold |=> row_signal_xfer && row_sel == 8'h00)
    else $error("first row does not follow the global hold");
  AST_ROW_STEPS: assert property (row_signal_xfer |=> row_pixel_reset ##1
    (row_reset_xfer && pixel_reset_on)) else $error("row transfer order broken");
  AST_VIDEO_START: assert property (row_reset_xfer |=> video_en && col_index == 9'h000
    && !video_sel_reset) else $error("video does not start at column zero");
  AST_SLOT_HALVES: assert property (frame_start_pulse && video_en &&
    ($rose(video_en) || $changed(col_index)) |-> !video_sel_reset ##1 !video_sel_reset
    ##1 video_sel_reset ##1 video_sel_reset) else $error("slot is not four cycles");
  AST_TRIG_PHASE: assert property (conversion_trigger |-> video_en && $past(video_en)
    && $stable(video_sel_reset) && $stable(col_index)) else $error("trigger misplaced");
  AST_COL_BOUND: assert property (video_en |-> col_index < NUM_COLS_P)
    else $error("column beyond the array");
  AST_COL_STEP: assert property (video_en && $past(video_en) && $changed(col_index)
    |-> col_index == $past(col_index) + 9'h001) else $error("column skipped");
  AST_NEXT_ROW: assert property (row_signal_xfer && !$past(global_hold) |->
    row_sel == row_seen_r + 8'h01 && gap_r >= ROW_BLANK_P && gap_r <= ROW_BLANK_P + 2)
    else $error("row step or row blank wrong");
  AST_LAST_ROW: assert property (frame_done |-> row_sel == NUM_ROWS_P - 1 && pixel_reset_on)
    else $error("frame ended before the last row");
  AST_RELEASE: assert property ($fell(pixel_reset_on) |-> integrating && !video_en)
    else $error("reset release without integration");
  AST_HOLD_CAUSE: assert property (global_hold |-> $past(frame_start_pulse)
    && $past(frame_start_pulse, 2)) else $error("hold without a high start pulse");
endmodule : readout_chk

bind frame_readout readout_chk #(.NUM_ROWS_P(NUM_ROWS_P), .NUM_COLS_P(NUM_COLS_P),
  .ROW_BLANK_P(ROW_BLANK_P)) u_chk (.clk, .rst_n, .frame_start_pulse, .integrating,
  .global_hold, .pixel_reset_on, .row_sel, .row_signal_xfer, .row_pixel_reset,
  .row_reset_xfer, .video_en, .video_sel_reset, .col_index, .conversion_trigger,
  .frame_done);

//--- testbench/ctrl_model.sv
// camera controller model: drives the start pin and pairs converter samples
// assumes req and low_len change only just after a rising clock edge
`timescale 1ns/1ps
module ctrl_model
  import readout_pkg::*;
(
  input  wire logic        clk,                // pixel clock
  input  wire logic        rst_n,              // reset, active low
  input  wire logic        req,                // start a low period
  input  wire logic [31:0] low_len,            // low period in clocks
  input  wire logic conversion_trigger, // converter strobe
  input  wire logic video_sel_reset,    // half of slot
  output logic      frame_start_pulse,  // start pin
  output int        pairs               // signal and reset pairs taken
);
  int   left = 0;
  logic take;
  logic seen_sig;
  // low for the minimum count at least; pin idles high, one writer only
  always @(posedge clk) begin
    take = req;
    #1;
    if (take && left == 0) left = (low_len < MIN_LOW_PULSES) ? MIN_LOW_PULSES : low_len;
    frame_start_pulse = (left == 0);
    if (left > 0) left--;
  end
  // a pair is counted when a reset-level trigger follows a signal-level trigger
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pairs    <= 0;
      seen_sig <= 1'b0;
    end else if (conversion_trigger) begin
      seen_sig <= !video_sel_reset;
      if (video_sel_reset && seen_sig) pairs <= pairs + 1;
    end
  end
endmodule : ctrl_model

//--- testbench/test_global_shutter_frame_readout.sv
// self-checking bench for the frame readout sequencer on a shrunken array
// assumes the package, checker and controller model are compiled first
`timescale 1ns/1ps
module test_global_shutter_frame_readout
  import readout_pkg::*;
;
  localparam int ROWS_T = 3;
  localparam int COLS_T = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  int   low_len = 25;
  int   pairs;
  int   bad_count = 0;
  int   n_compared = 0;
  int   xfer_n = 0;
  logic fsp, integrating, global_hold, pixel_reset_on, row_active, sig_x, pix_rst, rst_x;
  logic video_en, sel_rst, trig, frame_done;
  logic [INTEG_W-1:0] integ_cycles;
  logic [ROW_W-1:0]   row_sel;
  logic [COL_W-1:0]   col_index;

  always #25 clk = ~clk;
  always @(posedge clk) if (sig_x === 1'b1) xfer_n++;

  frame_readout #(.NUM_ROWS_P(ROWS_T), .NUM_COLS_P(COLS_T), .ROW_BLANK_P(2)) u_dut (
    .clk(clk), .rst_n(rst_n), .frame_start_pulse(fsp), .integrating(integrating),
    .integ_cycles(integ_cycles), .global_hold(global_hold), .pixel_reset_on(pixel_reset_on),
    .row_sel(row_sel), .row_active(row_active), .row_signal_xfer(sig_x),
    .row_pixel_reset(pix_rst), .row_reset_xfer(rst_x), .video_en(video_en),
    .video_sel_reset(sel_rst), .col_index(col_index), .conversion_trigger(trig),
    .frame_done(frame_done));
  ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .req(req), .low_len(low_len),
    .conversion_trigger(trig), .video_sel_reset(sel_rst), .frame_start_pulse(fsp),
    .pairs(pairs));

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // bounded wait on one of the design's flags
  task automatic wait_for(input int which, input int bound);
    int n;
    n = 0;
    while (!((which == 0 && global_hold === 1'b1) || (which == 1 && frame_done === 1'b1) ||
             (which == 2 && integrating === 1'b1) || (which == 3 && video_en === 1'b1))) begin
      @(posedge clk);
      #1;
      n++;
      if (n > bound) begin
        bad_count++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
      end
    end
  endtask : wait_for

  task automatic request(input int len);
    @(posedge clk);
    #1;
    low_len = len;
    req = 1'b1;
    @(posedge clk);
    #1;
    req = 1'b0;
  endtask : request

  // full frame: integration length, row count and sample pairs
  task automatic frame_run(input int len);
    int p0;
    int x0;
    p0 = pairs;
    x0 = xfer_n;
    request(len);
    wait_for(2, 10);
    check(pixel_reset_on, 1'b0);
    wait_for(0, len + 10);
    check(integ_cycles, len);
    check(integrating, 1'b0);
    wait_for(1, 200);
    check(xfer_n - x0, ROWS_T);
    check(row_active, 1'b0);
    check(pairs - p0, ROWS_T * COLS_T);
    check(pixel_reset_on, 1'b1);
  endtask : frame_run

  // start pulse falls mid-scan: frame dropped, new integration measured
  task automatic abort_run();
    request(40);
    wait_for(3, 60);
    check(row_active, 1'b1);
    request(30);
    wait_for(2, 10);
    @(posedge clk);
    #1;
    check(video_en, 1'b0);
    wait_for(0, 40);
    check(integ_cycles, 30);
    wait_for(1, 200);
  endtask : abort_run

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(pixel_reset_on, 1'b1);
    check(integrating, 1'b0);
    frame_run(25);
    abort_run();
    frame_run(60);
    complete_run();
  end
endmodule : test_global_shutter_frame_readout
